/* File: fwd_arbiter.sv */
// multi-port video forwarding arbiter: four receive ports onto one
// output, best effort or lockstep, with its control/status registers
// assumes receive ports and transmitter are logic on the same clock
//
// Strobed register access was decided locally.
`timescale 1ns/1ps
`default_nettype none

module fwd_arbiter (
	input  wire logic                           clk,
	input  wire logic                           rst_n,
	input  wire logic                           ce,
	// register port
	input  wire logic [7:0]                     reg_addr,
	input  wire logic [7:0]                     reg_wdata,
	input  wire logic                           reg_wr,
	input  wire logic                           reg_rd,
	output logic      [7:0]                     reg_rdata,
	// receive ports
	input  wire logic [3:0]                     rx_valid,
	input  wire fwd_arb_pkg::rx_pkt_t [3:0]     rx_pkt,
	output logic      [3:0]                     rx_ready,
	// transmitter side
	output logic                                tx_valid,
	output fwd_arb_pkg::tx_pkt_t                tx_pkt,
	input  wire logic                           tx_ready,
	// interrupt
	output logic                                irq
);
	import fwd_arb_pkg::*;

	// ***********************************************************
	// registers
	// ***********************************************************
	logic [7:0]        port_ctrl_r;   // block bits in 7:4
	logic [7:0]        policy_r;      // forwarding_policy_ctrl
	logic              lost_r;        // out0_lockstep_lost
	logic              ok_r;          // lockstep achieved
	logic [1:0]        irq_sts_r;     // sticky events
	logic [1:0]        irq_mask_r;    // event enables
	logic [7:0]        rdata_r;       // read data, one cycle late

	// ***********************************************************
	// forwarding state
	// ***********************************************************
	logic [3:0]        sent_r;        // ports served this round
	logic              kind_long_r;   // kind of round's first packet
	logic              kind_end_r;    // frame end flag of first packet
	logic              round_bad_r;   // mismatch or stall timeout seen this round
	logic              frame_done_r;  // one synced frame delivered
	logic [WAIT_W-1:0] wait_r;        // stall timer
	logic              tx_valid_r;    // output stage full
	tx_pkt_t           tx_pkt_r;      // output stage data

	// ***********************************************************
	// decoded controls
	// ***********************************************************
	lockstep_mode_t    mode;          // selected lockstep variant
	logic              sync_on;       // any lockstep mode
	logic              rr_on;         // best effort active
	logic              swr_eff;       // send-when-ready in force
	logic [3:0]        enabled;       // ports taking part
	logic [3:0]        pending;       // enabled and not yet served
	logic              all_ready;     // every pending port has data
	logic              out_free;      // output stage can load
	logic [3:0]        eligible;      // ports allowed to go now
	logic [3:0]        grant;         // arbiter winner
	logic              take;          // a packet moves this cycle
	logic [1:0]        sel;           // index of the winner
	rx_pkt_t           head;          // winner's packet
	logic              round_first;   // first take of a round
	logic              mismatch;      // take differs from round kind
	logic              round_end;     // this take closes the round
	logic              timeout;       // stall reached the limit
	logic              loss;          // loss of lockstep detected
	logic              ok_rise;       // lockstep just gained
	logic              rd_status;     // status register read

	// one-hot to index
	function automatic logic [1:0] idx_of(input logic [3:0] oh);
		logic [1:0] r;
		r = 2'h0;
		for (int i = 0; i < NPORT; i++)
			if (oh[i])
				r = 2'(i);
		return r;
	endfunction

	// ***********************************************************
	// mode decode
	// ***********************************************************
	// mode field
	assign mode    = lockstep_mode_t'(policy_r[POL_MODE_LO +: 2]);
	assign sync_on = (mode != LS_OFF);
	// lockstep wins should software set both anyway
	assign rr_on   = policy_r[POL_RR_BIT] & ~sync_on;
	assign swr_eff = sync_on & policy_r[POL_SWR_BIT] &
		(mode != LS_CONCAT);
	// cleared block bit lets a port forward
	assign enabled = ~port_ctrl_r[PORT_BLOCK_LO +: NPORT];

	assign pending   = enabled & ~sent_r;
	assign all_ready = (&(rx_valid | ~pending)) & (|pending);
	assign out_free  = ~tx_valid_r | tx_ready;
	assign rd_status = reg_rd & (reg_addr == ADDR_STATUS);

	// ***********************************************************
	// eligibility per port
	// ***********************************************************
	always_comb begin
		for (int i = 0; i < NPORT; i++) begin
			if (!out_free)
				eligible[i] = 1'b0;       // output stalled
			else if (rr_on)
				eligible[i] = enabled[i] & rx_valid[i];
			else if (sync_on)
				// wait for all; long lines may go early
				eligible[i] = pending[i] & rx_valid[i] &
					(all_ready | (swr_eff & rx_pkt[i].is_long));
			else
				// nothing forwarded with no mode on
				eligible[i] = 1'b0;
		end
	end

	// ***********************************************************
	// arbiter and handshakes
	// ***********************************************************
	// round-robin order among eligible ports
	rr_grant u_rr (
		.clk   (clk),
		.rst_n (rst_n),
		.ce    (ce),
		.req   (eligible),
		.grant (grant)
	);

	assign take     = |grant;
	assign rx_ready = ce ? grant : 4'h0;
	assign sel      = idx_of(grant);
	assign head     = rx_pkt[sel];

	// round bookkeeping terms
	assign round_first = sync_on & take & ~(|sent_r);
	assign mismatch    = sync_on & take & ~round_first &
		((head.is_long != kind_long_r) |
		 (head.frame_end != kind_end_r));
	assign round_end   = sync_on & take &
		((sent_r | grant) == enabled);
	assign timeout     = sync_on &
		(wait_r == WAIT_W'(SYNC_WAIT_CYC - 1));
	assign loss        = mismatch | timeout;
	assign ok_rise     = round_end & ~round_bad_r & ~mismatch & ~ok_r;

	// ***********************************************************
	// output stage
	// ***********************************************************
	// data leave from flops; loads only when the stage is free
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_valid_r <= 1'b0;
			tx_pkt_r   <= '0;
		end else if (ce && out_free) begin
			tx_valid_r <= take;
			if (take) begin
				tx_pkt_r.port   <= sel;
				tx_pkt_r.concat <= (mode == LS_CONCAT);
				tx_pkt_r.pkt    <= head;
			end
		end
	end

	assign tx_valid = tx_valid_r;
	assign tx_pkt   = tx_pkt_r;

	// ***********************************************************
	// round tracking
	// ***********************************************************
	// a round is one packet from each enabled port
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sent_r      <= 4'h0;
			kind_long_r <= 1'b0;
			kind_end_r  <= 1'b0;
			round_bad_r <= 1'b0;
		end else if (ce) begin
			if (!sync_on) begin
				// leaving lockstep drops a half round
				sent_r      <= 4'h0;
				round_bad_r <= 1'b0;
			end else if (round_end) begin
				sent_r      <= 4'h0;
				round_bad_r <= 1'b0;
			end else if (take) begin
				sent_r <= sent_r | grant;
				if (round_first) begin
					kind_long_r <= head.is_long;
					kind_end_r  <= head.frame_end;
				end
				if (mismatch)
					round_bad_r <= 1'b1;
			end else if (timeout) begin
				round_bad_r <= 1'b1;
			end
		end
	end

	// ***********************************************************
	// stall timer
	// ***********************************************************
	// counts while a lockstep round waits on a missing port;
	// a stuck port would otherwise hide the loss forever
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			wait_r <= '0;
		else if (ce) begin
			if (!sync_on || take || timeout)
				wait_r <= '0;
			else if ((|sent_r) || (|(rx_valid & pending)))
				wait_r <= wait_r + WAIT_W'(1);
			else
				wait_r <= '0;
		end
	end

	// ***********************************************************
	// lockstep status
	// ***********************************************************
	// ok after a clean round, dropped on any loss
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			ok_r <= 1'b0;
		else if (ce) begin
			if (!sync_on || loss)
				ok_r <= 1'b0;
			else if (round_end && !round_bad_r)
				ok_r <= 1'b1;
		end
	end

	// a frame counts once its closing round was clean
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			frame_done_r <= 1'b0;
		else if (ce) begin
			if (!sync_on)
				frame_done_r <= 1'b0;
			// a lone enabled port opens and closes its round at once,
			// so the stored kind is not loaded yet on that take
			else if (round_end && !round_bad_r && !mismatch &&
				(round_first || kind_end_r) && head.frame_end)
				frame_done_r <= 1'b1;
		end
	end

	// lost only after a delivered frame; read clears
	// a loss in the read cycle still sets
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			lost_r <= 1'b0;
		else if (ce) begin
			if (loss && frame_done_r)
				lost_r <= 1'b1;
			else if (rd_status)
				lost_r <= 1'b0;
		end
	end

	// ***********************************************************
	// control registers
	// ***********************************************************
	// blocked at reset; mode off, best effort on
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			port_ctrl_r <= PORT_CTRL_RST;
			policy_r    <= POLICY_RST;
			irq_mask_r  <= IRQ_MASK_RST[1:0];
		end else if (ce && reg_wr) begin
			case (reg_addr)
				ADDR_PORT_CTRL: port_ctrl_r <= reg_wdata;
				ADDR_POLICY:    policy_r    <= reg_wdata;
				ADDR_IRQ_MASK:  irq_mask_r  <= reg_wdata[1:0];
				default: ;      // other offsets ignore writes here; irq status clears below
			endcase
		end
	end

	// ***********************************************************
	// interrupt status
	// ***********************************************************
	// sticky events, write one to clear, set wins over clear
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			irq_sts_r <= 2'h0;
		else if (ce) begin
			for (int i = 0; i < 2; i++) begin
				if ((i == IRQ_LOST_BIT && loss && frame_done_r) ||
					(i == IRQ_OK_BIT && ok_rise))
					irq_sts_r[i] <= 1'b1;
				else if (reg_wr && reg_addr == ADDR_IRQ_STS &&
					reg_wdata[i])
					irq_sts_r[i] <= 1'b0;
			end
		end
	end

	// level output, high while an enabled event is pending
	assign irq = |(irq_sts_r & irq_mask_r);

	// ***********************************************************
	// read path
	// ***********************************************************
	// data stand for the one cycle after the strobe only
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			rdata_r <= 8'h00;
		else if (ce) begin
			rdata_r <= 8'h00;
			if (reg_rd) begin
				case (reg_addr)
					ADDR_PORT_CTRL: rdata_r <= port_ctrl_r;
					ADDR_POLICY:    rdata_r <= policy_r;
					ADDR_STATUS: begin
						rdata_r[STS_LOST_BIT] <= lost_r;
						rdata_r[STS_OK_BIT]   <= ok_r & sync_on;
					end
					ADDR_IRQ_STS:   rdata_r <= {6'h00, irq_sts_r};
					ADDR_IRQ_MASK:  rdata_r <= {6'h00, irq_mask_r};
					default:        rdata_r <= 8'h00; // unmapped
				endcase
			end
		end
	end

	assign reg_rdata = rdata_r;

endmodule // fwd_arbiter

`default_nettype wire

/* File: fwd_arb_pkg.sv */
// constants, types and register layout of the video forwarding arbiter
// assumes one 100 MHz clock and an 8-bit register port
`default_nettype none

package fwd_arb_pkg;

	// ***********************************************************
	// sizes
	// ***********************************************************
	localparam int NPORT = 4;                 // receive ports
	localparam int PW    = 32;                // packet word width

	// ***********************************************************
	// register offsets
	// ***********************************************************
	localparam logic [7:0] ADDR_PORT_CTRL = 8'h20; // per-port block bits
	localparam logic [7:0] ADDR_POLICY    = 8'h21; // forwarding policy
	localparam logic [7:0] ADDR_STATUS    = 8'h22; // lockstep status
	localparam logic [7:0] ADDR_IRQ_STS   = 8'h30; // sticky events
	localparam logic [7:0] ADDR_IRQ_MASK  = 8'h31; // event mask

	// ***********************************************************
	// field positions
	// ***********************************************************
	localparam int PORT_BLOCK_LO = 4;         // rx0_forward_block .. rx3
	localparam int POL_SWR_BIT   = 6;         // sync_send_when_ready
	localparam int POL_MODE_LO   = 2;         // out0_lockstep_mode 3:2
	localparam int POL_RR_BIT    = 0;         // out0_best_effort_en
	localparam int STS_LOST_BIT  = 2;         // out0_lockstep_lost
	localparam int STS_OK_BIT    = 0;         // out0_lockstep_ok
	localparam int IRQ_LOST_BIT  = 0;         // lockstep lost event
	localparam int IRQ_OK_BIT    = 1;         // lockstep gained event

	// ***********************************************************
	// values after reset
	// ***********************************************************
	localparam logic [7:0] PORT_CTRL_RST = 8'hf0; // all ports blocked
	localparam logic [7:0] POLICY_RST    = 8'h03; // best effort on
	localparam logic [7:0] IRQ_MASK_RST  = 8'h00; // all masked

	// ***********************************************************
	// timing
	// ***********************************************************
	localparam int CLK_PERIOD_NS = 10;        // 100 MHz
	localparam int SYNC_WAIT_NS  = 10000;     // stall before loss
	localparam int SYNC_WAIT_CYC =
		(SYNC_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WAIT_W = 10;               // timer width

	// ***********************************************************
	// types
	// ***********************************************************
	typedef enum logic [1:0] {
		LS_OFF        = 2'b00,
		LS_BASIC      = 2'b01,
		LS_INTERLEAVE = 2'b10,
		LS_CONCAT     = 2'b11
	} lockstep_mode_t;

	// one packet at the head of a receive port
	typedef struct packed {
		logic          is_long;   // video line, else sync short packet
		logic          frame_end; // short packet closing a frame
		logic [PW-1:0] payload;
	} rx_pkt_t;

	// one packet handed to the transmitter
	typedef struct packed {
		logic [1:0] port;         // source receive port
		logic       concat;       // part of a concatenated line
		rx_pkt_t    pkt;
	} tx_pkt_t;

endpackage

`default_nettype wire

/* File: rr_grant.sv */
// round-robin one-hot grant among four requesters
// assumes requests are stable within the cycle they are granted
`timescale 1ns/1ps
`default_nettype none

module rr_grant (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       ce,
	input  wire logic [3:0] req,
	output logic      [3:0] grant
);
	import fwd_arb_pkg::*;

	// ***********************************************************
	// priority pointer
	// ***********************************************************
	logic [1:0] ptr_r;   // requester with top priority

	// first request at or after the pointer, one-hot
	function automatic logic [3:0] pick(input logic [3:0] r,
		input logic [1:0] p);
		logic [3:0] g;
		logic [1:0] k;
		g = 4'h0;
		for (int i = 3; i >= 0; i--) begin
			k = p + 2'(i);
			if (r[k])
				g = 4'h1 << k;
		end
		return g;
	endfunction

	// combinational so the winner is taken in the same cycle
	always_comb begin
		grant = pick(req, ptr_r);
	end

	// move the pointer past the last winner for fairness
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			ptr_r <= 2'h0;
		else if (ce && |grant) begin
			for (int i = 0; i < NPORT; i++)
				if (grant[i])
					ptr_r <= 2'(i + 1);
		end
	end

endmodule // rr_grant

`default_nettype wire

/* File: fwd_arb_checker_assertions.sv */
// checker of the forwarding arbiter, watching its top ports only
// assumes one clock domain; bound into every fwd_arbiter
`timescale 1ns/1ps
`default_nettype none

module fwd_arb_checker (
	input wire logic                       clk,
	input wire logic                       rst_n,
	input wire logic                       ce,
	input wire logic [7:0]                 reg_addr,
	input wire logic [7:0]                 reg_wdata,
	input wire logic                       reg_wr,
	input wire logic                       reg_rd,
	input wire logic [7:0]                 reg_rdata,
	input wire logic [3:0]                 rx_valid,
	input wire fwd_arb_pkg::rx_pkt_t [3:0] rx_pkt,
	input wire logic [3:0]                 rx_ready,
	input wire logic                       tx_valid,
	input wire fwd_arb_pkg::tx_pkt_t       tx_pkt,
	input wire logic                       tx_ready,
	input wire logic                       irq
);
	import fwd_arb_pkg::*;

	// ****************
	// shadow registers
	// ****************
	logic [7:0] blk_r;   // port block bits
	logic [7:0] pol_r;   // forwarding policy
	logic [7:0] msk_r;   // interrupt mask
	logic [1:0] acc_idx; // port readied now

	// follow taken writes so rules can see the setup
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			blk_r <= 8'hf0;
			pol_r <= 8'h03;
			msk_r <= 8'h00;
		end else if (ce && reg_wr) begin
			case (reg_addr)
			ADDR_PORT_CTRL: blk_r <= reg_wdata;
			ADDR_POLICY:    pol_r <= reg_wdata;
			ADDR_IRQ_MASK:  msk_r <= reg_wdata;
			default: ;
			endcase
		end
	end

	// index of the one readied port
	always_comb begin
		acc_idx = 2'd0;
		for (int i = 0; i < NPORT; i++)
			if (rx_ready[i]) acc_idx = 2'(i);
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	// ****************
	// assertions
	// ****************
	rdata_idle_a: assert property (
		$past(ce && !reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data not zero outside a read");
	one_ready_a: assert property ($onehot0(rx_ready))
		else $error("several ports readied");
	blocked_port_a: assert property ((rx_ready & blk_r[7:4]) == 4'h0)
		else $error("blocked port readied");
	no_mode_a: assert property (
		pol_r[1'b0] == 1'b0 && pol_r[3:2] == 2'b00 |-> rx_ready == 4'h0)
		else $error("port readied with no mode");
	ok_off_a: assert property ($past(ce && reg_rd &&
		reg_addr == ADDR_STATUS && pol_r[3:2] == 2'b00) |-> !reg_rdata[0])
		else $error("ok flag set with lockstep off");
	tx_hold_a: assert property (
		tx_valid && !tx_ready |=> tx_valid && $stable(tx_pkt))
		else $error("output packet dropped or changed in stall");
	accept_tx_a: assert property (ce && (rx_valid & rx_ready) != 4'h0
		|=> tx_valid && tx_pkt.port == $past(acc_idx)
		&& tx_pkt.pkt == $past(rx_pkt[acc_idx])
		&& tx_pkt.concat == $past(pol_r[3:2] == 2'b11))
		else $error("taken packet not presented next cycle");
	stage_free_a: assert property (rx_ready != 4'h0 |-> !tx_valid || tx_ready)
		else $error("port readied while stage full");
	irq_mask_a: assert property (msk_r == 8'h00 |-> !irq)
		else $error("interrupt with all events masked");
	policy_read_a: assert property ($past(ce && reg_rd &&
		reg_addr == ADDR_POLICY) |-> reg_rdata == $past(pol_r))
		else $error("policy read back wrong");

	// main scenarios reached
	lockstep_c: cover property (tx_valid && tx_ready && pol_r[3:2] != 2'b00);
	stall_c: cover property (tx_valid && !tx_ready);
	irq_c: cover property (irq);
endmodule // fwd_arb_checker

bind fwd_arbiter fwd_arb_checker chk_u (.clk(clk), .rst_n(rst_n),
	.ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.rx_valid(rx_valid), .rx_pkt(rx_pkt), .rx_ready(rx_ready),
	.tx_valid(tx_valid), .tx_pkt(tx_pkt), .tx_ready(tx_ready),
	.irq(irq));

`default_nettype wire

/* File: video_sink.sv */
// downstream receiver model: takes packets off the output stage
// assumes the arbiter's valid/ready stream on the same clock
`timescale 1ns/1ps
`default_nettype none

module video_sink (
	input  wire logic                 clk,
	input  wire logic                 rst_n,
	input  wire logic                 stall,
	input  wire logic                 tx_valid,
	input  wire fwd_arb_pkg::tx_pkt_t tx_pkt,
	output logic                      tx_ready,
	output logic [3:0][7:0]           cnt
);
	import fwd_arb_pkg::*;

	// ready lags stall by a cycle, like a registered back-pressure
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			tx_ready <= 1'b0;
		else
			tx_ready <= !stall;
	end

	// per-port count of accepted packets
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			cnt <= '0;
		else if (tx_valid && tx_ready)
			cnt[tx_pkt.port] <= cnt[tx_pkt.port] + 8'd1;
	end
endmodule // video_sink

`default_nettype wire

/* File: tb_multi_port_video_forwarding_arbiter.sv */
// testbench of the forwarding arbiter: registers, stream, status
// assumes fwd_arbiter, video_sink and the bound checker
`timescale 1ns/1ps
`default_nettype none

module tb_multi_port_video_forwarding_arbiter;
	import fwd_arb_pkg::*;

	// ****************
	// signals
	// ****************
	logic            clk = 1'b0;
	logic            rst_n = 1'b0;
	logic            ce = 1'b1;      // never frozen
	logic [7:0]      reg_addr = 8'h00;
	logic [7:0]      reg_wdata = 8'h00;
	logic            reg_wr = 1'b0;
	logic            reg_rd = 1'b0;
	logic [7:0]      reg_rdata;
	logic [3:0]      rx_valid = 4'h0;
	rx_pkt_t [3:0]   rx_pkt = '0;
	logic [3:0]      rx_ready;
	logic            tx_valid;
	tx_pkt_t         tx_pkt;
	logic            tx_ready;
	logic            irq;
	logic            stall = 1'b0;   // sink back-pressure
	logic [3:0][7:0] cnt;            // packets per port
	logic [7:0]      n0;             // count snapshot
	int              fails = 0;
	int              samples_checked = 0;
	// reset table: address, value; the last place is unmapped
	logic [7:0] ra [6] = '{8'h20, 8'h21, 8'h22, 8'h30, 8'h31, 8'h40};
	logic [7:0] rv [6] = '{8'hf0, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00};
	// one lone port: policy, long line, lines expected out
	logic [7:0] swp [4] = '{8'h46, 8'h46, 8'h4e, 8'h0a};
	logic       swl [4] = '{1'b1, 1'b0, 1'b1, 1'b1};
	logic [7:0] swe [4] = '{8'h01, 8'h00, 8'h00, 8'h00};

	always #(CLK_PERIOD_NS / 2) clk = ~clk;

	fwd_arbiter dut_u (.clk(clk), .rst_n(rst_n), .ce(ce),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_valid(rx_valid),
		.rx_pkt(rx_pkt), .rx_ready(rx_ready), .tx_valid(tx_valid),
		.tx_pkt(tx_pkt), .tx_ready(tx_ready), .irq(irq));
	video_sink sink_u (.clk(clk), .rst_n(rst_n), .stall(stall),
		.tx_valid(tx_valid), .tx_pkt(tx_pkt), .tx_ready(tx_ready),
		.cnt(cnt));

	// ****************
	// tasks
	// ****************
	task automatic check(input logic [7:0] got, input logic [7:0] exp,
		input logic [7:0] msk);
		samples_checked++;
		if ((got & msk) !== exp) begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, got & msk,
				exp);
		end
	endtask

	// cycles, then step off the edge so outputs are settled
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	// data stand only in the cycle after the read edge
	task automatic rd(input logic [7:0] a, input logic [7:0] exp,
		input logic [7:0] msk);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		check(reg_rdata, exp, msk);
	endtask

	task drive(input int p, input logic v, input logic lng,
		input logic fe);
		rx_valid[p] <= v;
		rx_pkt[p] <= '{is_long: lng, frame_end: fe,
			payload: 32'ha5a50000 | p};
	endtask

	// fresh start, ports 0 and 1 enabled, given policy
	task automatic boot(input logic [7:0] pol);
		rst_n <= 1'b0;
		rx_valid <= 4'h0;
		cyc(8);
		rst_n <= 1'b1;
		wr(ADDR_PORT_CTRL, 8'hc0);
		wr(ADDR_POLICY, pol);
	endtask

	task automatic stop_test;
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// the whole run takes some 400 cycles
	initial begin
		#200000;
		fails++;
		stop_test;
	end

	// ****************
	// scenarios
	// ****************
	initial begin
		cyc(8);
		rst_n <= 1'b1;
		for (int i = 0; i < 6; i++)
			rd(ra[i], rv[i], 8'hff);
		// every port offers data, all still blocked
		for (int p = 0; p < NPORT; p++)
			drive(p, 1'b1, 1'b1, 1'b0);
		cyc(10);
		check(cnt[0] | cnt[1] | cnt[2] | cnt[3], 8'h00, 8'hff);
		wr(ADDR_PORT_CTRL, 8'hc0);
		cyc(40);
		check({7'h0, cnt[0] >= 8'd15}, 8'h01, 8'hff);
		check(cnt[0] - cnt[1], 8'h00, 8'hfe);
		check(cnt[2] | cnt[3], 8'h00, 8'hff);
		// receiver stalls: nothing moves, the packet waits
		stall <= 1'b1;
		cyc(3);
		n0 = cnt[0] + cnt[1];
		cyc(10);
		check(cnt[0] + cnt[1], n0, 8'hff);
		check({7'h0, tx_valid}, 8'h01, 8'hff);
		stall <= 1'b0;
		// no mode at all forwards nothing
		wr(ADDR_POLICY, 8'h02);
		cyc(3);
		n0 = cnt[0] + cnt[1];
		cyc(20);
		check(cnt[0] + cnt[1], n0, 8'hff);
		rd(ADDR_STATUS, 8'h00, 8'h01);
		// lockstep holds port 0 until port 1 has a line
		boot(8'h06);
		drive(0, 1'b1, 1'b1, 1'b0);
		cyc(20);
		check(cnt[0], 8'h00, 8'hff);
		drive(1, 1'b1, 1'b1, 1'b0);
		cyc(20);
		check({7'h0, cnt[1] >= 8'd5}, 8'h01, 8'hff);
		check(cnt[0] - cnt[1], 8'h00, 8'hfe);
		rd(ADDR_STATUS, 8'h01, 8'h01);
		// concatenation still forwards full rounds, marked as such
		wr(ADDR_POLICY, 8'h4e);
		cyc(10);
		check({7'h0, tx_pkt.concat}, 8'h01, 8'hff);
		// a lone port under send-when-ready and the other modes
		for (int k = 0; k < 4; k++) begin
			boot(swp[k]);
			drive(0, 1'b1, swl[k], 1'b0);
			cyc(20);
			check(cnt[0], swe[k], 8'hff);
		end
		// mismatch before any synced frame is no loss
		boot(8'h06);
		drive(0, 1'b1, 1'b1, 1'b0);
		drive(1, 1'b1, 1'b0, 1'b0);
		cyc(20);
		rd(ADDR_STATUS, 8'h00, 8'h04);
		// synced frames, then a mismatch
		boot(8'h06);
		wr(ADDR_IRQ_MASK, 8'h01);
		drive(0, 1'b1, 1'b0, 1'b1);
		drive(1, 1'b1, 1'b0, 1'b1);
		cyc(20);
		drive(1, 1'b1, 1'b1, 1'b0);
		cyc(10);
		wr(ADDR_POLICY, 8'h02);
		cyc(2);
		check({7'h0, irq}, 8'h01, 8'hff);
		rd(ADDR_STATUS, 8'h04, 8'h05);
		rd(ADDR_STATUS, 8'h00, 8'h04);
		// mask, unmask, then clear by writing one
		wr(ADDR_IRQ_MASK, 8'h00);
		cyc(1);
		check({7'h0, irq}, 8'h00, 8'hff);
		wr(ADDR_IRQ_MASK, 8'h01);
		cyc(1);
		check({7'h0, irq}, 8'h01, 8'hff);
		rd(ADDR_IRQ_STS, 8'h03, 8'h03);
		wr(ADDR_IRQ_STS, 8'h01);
		cyc(1);
		check({7'h0, irq}, 8'h00, 8'hff);
		stop_test;
	end
endmodule // tb_multi_port_video_forwarding_arbiter

`default_nettype wire
